// *** hdl/pprc_timer.sv ***
/*
  Pin timing block: RC discharge reading and pulse width capture.
  Assumes pin inputs synchronous to clk; parameters steady while busy.
*/
// How it works
// R1: RC reading takes pin 0..7, drives it out, later releases it.
// R2: Pin driven high for 10 ms charge before timing begins.
// R3: Then pin becomes input, counter runs until pin first reads low.
// R4: Count times scale, divided by 256, gives the reading.
// R5: Scale is unsigned 0..255.
// R6: RC result is 8 bits, scaled from 16-bit count.
// R7: Capture takes pin 0..15 and leaves it an input.
// R8: Polarity 0 captures low pulse, 1 captures high pulse.
// R9: After start edge, count ticks until opposite edge, report count.
// R10: Capture tick is 10 us, 2 us or 0.8 us by variant.
// R11: No start edge within maximum width reports zero.
// R12: Pulse longer than maximum width reports zero.
// R13: Capture always counts in 16 bits.
// R14: Byte result keeps lower 8 bits, no saturation.
// R15: One-cycle done per result; requests ignored while busy.
`timescale 1ns/10ps
module pprc_timer #(
  parameter int CHARGE_CYCLES = pprc_pkg::CHARGE_CYC
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [1:0]  unit_sel,
  input  wire logic        rc_start,
  input  wire logic [2:0]  rc_pin,
  input  wire logic [7:0]  rc_scale,
  output logic [7:0]       rc_result,
  output logic             rc_done,
  input  wire logic        cap_start,
  input  wire logic [3:0]  cap_pin,
  input  wire logic        cap_polarity,
  output logic [15:0]      cap_result,
  output logic [7:0]       cap_result_byte,
  output logic             cap_done,
  output logic             busy,
  input  wire logic [15:0] pin_in,
  output logic [15:0]      pin_out,
  output logic [15:0]      pin_oe
);
  pprc_pkg::pprc_state_t state;
  logic                  is_rc;
  logic [3:0]            sel;
  logic                  pol;
  logic [7:0]            scale;
  logic [31:0]           charge_cnt;
  logic [15:0]           cnt;
  logic                  prev;
  logic                  tick;
  logic                  restart;
  logic                  pin_now;
  logic [23:0]           product;
  logic                  timeout;

  assign pin_now = pin_in[sel];
  assign busy    = (state != pprc_pkg::PPRC_IDLE);
  assign restart = (state == pprc_pkg::PPRC_IDLE);
  assign timeout = tick && (cnt == pprc_pkg::CNT_MAX);
  assign product = cnt * scale; // see R4

  pprc_tick u_tick (
    .clk      (clk),
    .nrst     (nrst),
    .restart  (restart),
    .unit_sel (unit_sel), // see R10
    .tick     (tick)
  );

  // Command capture; starts ignored while busy
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      is_rc <= 1'b0;
      sel   <= '0;
      pol   <= 1'b0;
      scale <= '0;
    end
    else if (state == pprc_pkg::PPRC_IDLE && rc_start) // see R15
    begin
      is_rc <= 1'b1;
      sel   <= {1'b0, rc_pin}; // see R1
      scale <= rc_scale; // see R5
    end
    else if (state == pprc_pkg::PPRC_IDLE && cap_start)
    begin
      is_rc <= 1'b0;
      sel   <= cap_pin; // see R7
      pol   <= cap_polarity; // see R8
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      state <= pprc_pkg::PPRC_IDLE;
    else
      case (state)
        pprc_pkg::PPRC_IDLE:
          if (rc_start)
            state <= pprc_pkg::PPRC_CHARGE;
          else if (cap_start)
            state <= pprc_pkg::PPRC_WSTART;
        pprc_pkg::PPRC_CHARGE:
          if (charge_cnt == 32'(CHARGE_CYCLES - 1)) // see R2
            state <= pprc_pkg::PPRC_DISCH;
        pprc_pkg::PPRC_DISCH:
          if (!pin_now) // see R3
            state <= pprc_pkg::PPRC_DONE;
        pprc_pkg::PPRC_WSTART:
          if (prev != pol && pin_now == pol) // see R8
            state <= pprc_pkg::PPRC_WEND;
          else if (timeout) // see R11
            state <= pprc_pkg::PPRC_DONE;
        pprc_pkg::PPRC_WEND:
          if (pin_now != pol || timeout) // see R9 R12
            state <= pprc_pkg::PPRC_DONE;
        pprc_pkg::PPRC_DONE:
          state <= pprc_pkg::PPRC_IDLE;
        default:
          state <= pprc_pkg::PPRC_IDLE;
      endcase
  end

  // Previous pin level for edge detection
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      prev <= 1'b0;
    else if (state == pprc_pkg::PPRC_IDLE && cap_start)
      prev <= pin_in[cap_pin];
    else
      prev <= pin_now;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      charge_cnt <= '0;
    else if (state == pprc_pkg::PPRC_CHARGE)
      charge_cnt <= charge_cnt + 32'h1;
    else
      charge_cnt <= '0;
  end

  // 16-bit counter: wait timer, then width counter; saturates at max in discharge, wraps on capture timeout
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cnt <= '0;
    else
      case (state)
        pprc_pkg::PPRC_IDLE, pprc_pkg::PPRC_CHARGE:
          cnt <= '0;
        pprc_pkg::PPRC_DISCH:
          if (pin_now && tick && cnt != pprc_pkg::CNT_MAX)
            cnt <= cnt + 16'h1; // see R3
        pprc_pkg::PPRC_WSTART:
          if (prev != pol && pin_now == pol)
            cnt <= '0;
          else if (tick)
            cnt <= cnt + 16'h1;
        pprc_pkg::PPRC_WEND:
          if (tick && pin_now == pol)
            cnt <= cnt + 16'h1; // see R9 R13
        default:
          cnt <= cnt;
      endcase
  end

  // Results and done pulses
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rc_result       <= '0;
      cap_result      <= '0;
      cap_result_byte <= '0;
      rc_done         <= 1'b0;
      cap_done        <= 1'b0;
    end
    else
    begin
      rc_done  <= 1'b0;
      cap_done <= 1'b0;
      if (state == pprc_pkg::PPRC_DISCH && !pin_now)
      begin
        rc_result <= product[pprc_pkg::SCALE_SHIFT +: pprc_pkg::RES_W]; // see R4 R6
        rc_done   <= 1'b1; // see R15
      end
      else if ((state == pprc_pkg::PPRC_WSTART && timeout &&
                !(prev != pol && pin_now == pol)) ||
               (state == pprc_pkg::PPRC_WEND && timeout &&
                pin_now == pol))
      begin
        cap_result      <= '0; // see R11 R12
        cap_result_byte <= '0;
        cap_done        <= 1'b1;
      end
      else if (state == pprc_pkg::PPRC_WEND && pin_now != pol)
      begin
        cap_result      <= cnt;
        cap_result_byte <= cnt[pprc_pkg::RES_W-1:0]; // see R14
        cap_done        <= 1'b1;
      end
    end
  end

  // Pin drive: only the selected RC pin, high during charge
  always_comb
  begin
    pin_out = '0;
    pin_oe  = '0;
    if (state == pprc_pkg::PPRC_CHARGE && is_rc)
    begin
      pin_out[sel] = 1'b1; // see R1 R2
      pin_oe[sel]  = 1'b1;
    end
  end

  property p_charge_drive;
    @(posedge clk) disable iff (!nrst)
      (state == pprc_pkg::PPRC_CHARGE) |-> pin_oe[sel] && pin_out[sel];
  endproperty
  a_charge_drive: assert property (p_charge_drive) // see R2
    else $error("Pin not driven high during charge");

  property p_disch_release;
    @(posedge clk) disable iff (!nrst)
      (state == pprc_pkg::PPRC_DISCH) |-> pin_oe == 16'h0000;
  endproperty
  a_disch_release: assert property (p_disch_release) // see R3
    else $error("Pin still driven while discharging");

  property p_cap_no_drive;
    @(posedge clk) disable iff (!nrst)
      (!is_rc && busy) |-> pin_oe == 16'h0000;
  endproperty
  a_cap_no_drive: assert property (p_cap_no_drive) // see R7
    else $error("Capture pin driven");

  sequence s_rc_req;
    state == pprc_pkg::PPRC_IDLE && rc_start;
  endsequence
  property p_rc_enter;
    @(posedge clk) disable iff (!nrst)
      s_rc_req |=> state == pprc_pkg::PPRC_CHARGE;
  endproperty
  a_rc_enter: assert property (p_rc_enter) // see R1
    else $error("RC request did not start charge");

  property p_rc_stop;
    @(posedge clk) disable iff (!nrst)
      (state == pprc_pkg::PPRC_DISCH && !pin_now) |=>
        rc_done && rc_result == $past(product[15:8]);
  endproperty
  a_rc_stop: assert property (p_rc_stop) // see R4
    else $error("RC result wrong or late");

  property p_done_pulse;
    @(posedge clk) disable iff (!nrst)
      (rc_done || cap_done) |=> !rc_done && !cap_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) // see R15
    else $error("Done longer than one cycle");

  property p_byte_low;
    @(posedge clk) disable iff (!nrst)
      cap_done |-> cap_result_byte == cap_result[7:0];
  endproperty
  a_byte_low: assert property (p_byte_low) // see R14
    else $error("Byte result not low bits");

  property p_width_end;
    @(posedge clk) disable iff (!nrst)
      (state == pprc_pkg::PPRC_WEND && pin_now != pol) |=>
        cap_done && cap_result == $past(cnt);
  endproperty
  a_width_end: assert property (p_width_end) // see R9
    else $error("Capture result not the width count");

  property p_timeout_zero;
    @(posedge clk) disable iff (!nrst)
      (state == pprc_pkg::PPRC_WSTART && timeout &&
       !(prev != pol && pin_now == pol)) |=>
        cap_done && cap_result == 16'h0000;
  endproperty
  a_timeout_zero: assert property (p_timeout_zero) // see R11
    else $error("Start timeout did not report zero");
endmodule // pprc_timer

// *** pkg/pprc_pkg.sv ***
/*
  Constants for the pin pulse and RC discharge timer.
  Assumes a single 250 MHz clock; nothing else.
*/
package pprc_pkg;
  localparam int          CLK_MHZ        = 250;
  localparam int          CHARGE_MS      = 10;
  localparam int          CHARGE_CYC     = CHARGE_MS * 1000 * CLK_MHZ;
  localparam int          TICK_NS_10US   = 10000;
  localparam int          TICK_NS_2US    = 2000;
  localparam int          TICK_NS_0P8US  = 800;
  localparam int          TICK_CYC_10US  = TICK_NS_10US * CLK_MHZ / 1000;
  localparam int          TICK_CYC_2US   = TICK_NS_2US * CLK_MHZ / 1000;
  localparam int          TICK_CYC_0P8US = TICK_NS_0P8US * CLK_MHZ / 1000;
  localparam int          TICK_W         = 12;
  localparam int          CNT_W          = 16;
  localparam int          RES_W          = 8;
  localparam int          RC_PINS        = 8;
  localparam int          CAP_PINS       = 16;
  localparam logic [1:0]  TU_10US        = 2'h0;
  localparam logic [1:0]  TU_2US         = 2'h1;
  localparam logic [1:0]  TU_0P8US       = 2'h2;
  localparam logic [15:0] CNT_MAX        = 16'hffff;
  localparam int          SCALE_SHIFT    = 8;

  typedef enum logic [5:0] {
    PPRC_IDLE   = 6'h01,
    PPRC_CHARGE = 6'h02,
    PPRC_DISCH  = 6'h04,
    PPRC_WSTART = 6'h08,
    PPRC_WEND   = 6'h10,
    PPRC_DONE   = 6'h20
  } pprc_state_t;
endpackage

// *** hdl/pprc_tick.sv ***
/*
  Tick divider: one-cycle enable at the selected capture unit.
  Assumes restart is held high while idle and released when a measurement begins.
*/
`timescale 1ns/10ps
module pprc_tick (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       restart,
  input  wire logic [1:0] unit_sel,
  output logic            tick
);
  logic [pprc_pkg::TICK_W-1:0] cnt;
  logic [pprc_pkg::TICK_W-1:0] last;

  always_comb
  begin
    case (unit_sel)
      pprc_pkg::TU_2US:
        last = pprc_pkg::TICK_W'(pprc_pkg::TICK_CYC_2US - 1);
      pprc_pkg::TU_0P8US:
        last = pprc_pkg::TICK_W'(pprc_pkg::TICK_CYC_0P8US - 1);
      default:
        last = pprc_pkg::TICK_W'(pprc_pkg::TICK_CYC_10US - 1);
    endcase
  end

  assign tick = (cnt == last) && !restart;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cnt <= '0;
    else if (restart || cnt == last)
      cnt <= '0;
    else
      cnt <= cnt + 1'b1;
  end
endmodule // pprc_tick

// *** verification/pprc_pin_model.sv ***
/*
  External RC network and pulse source on the sixteen pins.
  Assumes the timer drives pin_out/pin_oe; ext sets undriven levels.
*/
`timescale 1ns/10ps
module pprc_pin_model (
  input  wire logic        clk,
  input  wire logic [15:0] pin_out,
  input  wire logic [15:0] pin_oe,
  input  wire logic [15:0] ext,
  input  wire integer      disch,
  output logic [15:0]      pin_in
);
  logic [15:0] charged = 16'h0;
  int          cnt     = 0;
  // Capacitor remembers the level it was charged to
  always_ff @(posedge clk)
  begin
    if (|pin_oe)
    begin
      charged <= pin_out & pin_oe;
      cnt     <= disch;
    end
    else if (cnt > 0)
      cnt <= cnt - 1;
  end
  // Released pin stays high until the capacitor has discharged
  assign pin_in = (pin_oe & pin_out) |
                  (~pin_oe & ((cnt > 0) ? charged : 16'h0)) |
                  (~pin_oe & ext);
endmodule // pprc_pin_model

// *** verification/testbench.sv ***
/*
  Self-checking bench for the pin timing block.
  Assumes the pin model stands on the pin side; short charge time.
*/
`timescale 1ns/10ps
module testbench;
  localparam int CH = 50;
  localparam int T  = pprc_pkg::TICK_CYC_0P8US;
  logic        clk = 0, nrst = 0, rc_start = 0, cap_start = 0;
  logic        rc_done, cap_done, busy, cap_polarity = 0;
  logic [1:0]  unit_sel = 2'h2;
  logic [2:0]  rc_pin = 3'h0;
  logic [3:0]  cap_pin = 4'h0;
  logic [7:0]  rc_scale = 8'h0, rc_result, cap_result_byte;
  logic [15:0] cap_result, pin_in, pin_out, pin_oe, ext = 16'h0;
  int          disch = 0, error_cnt = 0, samples_checked = 0, cap_seen = 0;
  always #2 clk = ~clk;
  always @(posedge clk) if (cap_done === 1'b1) cap_seen++;
  pprc_timer #(.CHARGE_CYCLES(CH)) i_pprc_timer (.clk(clk), .nrst(nrst),
    .unit_sel(unit_sel), .rc_start(rc_start), .rc_pin(rc_pin),
    .rc_scale(rc_scale), .rc_result(rc_result), .rc_done(rc_done),
    .cap_start(cap_start), .cap_pin(cap_pin), .cap_polarity(cap_polarity),
    .cap_result(cap_result), .cap_result_byte(cap_result_byte),
    .cap_done(cap_done), .busy(busy), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe));
  pprc_pin_model i_pprc_pin_model (.clk(clk), .pin_out(pin_out),
    .pin_oe(pin_oe), .ext(ext), .disch(disch), .pin_in(pin_in));
  task automatic chk(input string nm, input logic [15:0] e, got);
    samples_checked++;
    if (got !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, got);
    end
  endtask
  task automatic rng(input string nm, input int lo, hi, input logic [15:0] g);
    samples_checked++;
    if ($isunknown(g) || g < lo || g > hi)
    begin
      error_cnt++;
      $display("ERROR %s expected %0d..%0d seen %h", nm, lo, hi, g);
    end
  endtask
  task automatic wait_done(input bit is_cap);
    int n;
    n = 0;
    while ((is_cap ? cap_done : rc_done) !== 1'b1 && n < 40000)
    begin
      @(posedge clk);
      #1 n++;
    end
    chk("done seen", 1, is_cap ? cap_done : rc_done);
    @(posedge clk);
    #1 chk("done width", 0, is_cap ? cap_done : rc_done);
  endtask
  task automatic rc_read(input logic [2:0] p, input int s, d);
    int c0;
    c0 = cap_seen;
    disch = d;
    rc_pin = p;
    rc_scale = s[7:0];
    rc_start = 1;
    @(posedge clk);
    #1 rc_start = 0;
    cap_start = 1;
    @(posedge clk);
    #1 cap_start = 0;
    chk("busy", 1, busy);
    repeat (CH - 5) @(posedge clk);
    #1 chk("pin_oe", 16'h1 << p, pin_oe);
    chk("pin_out", 16'h1 << p, pin_out & pin_oe);
    wait_done(1'b0);
    chk("pin_oe off", 0, pin_oe);
    chk("refused", c0[15:0], cap_seen[15:0]);
    rng("rc_result", (d / T - 1) * s / 256, (d / T + 1) * s / 256,
        {8'h0, rc_result});
    $display("test rc pin %0d scale %0d ended", p, s);
  endtask
  task automatic cap_read(input logic [3:0] p, input logic pol,
                          input logic [1:0] u, input int w);
    int t;
    t = (u == 2'h1) ? pprc_pkg::TICK_CYC_2US :
        (u == 2'h2) ? T : pprc_pkg::TICK_CYC_10US;
    unit_sel = u;
    ext = pol ? 16'h0 : 16'hffff;
    cap_pin = p;
    cap_polarity = pol;
    cap_start = 1;
    @(posedge clk);
    #1 cap_start = 0;
    repeat (3) @(posedge clk);
    #1 chk("pin_oe cap", 0, pin_oe);
    ext[p] = pol;
    repeat (w) @(posedge clk);
    #1 ext[p] = ~pol;
    wait_done(1'b1);
    rng("cap_result", w / t - 1, w / t + 1, cap_result);
    rng("cap_byte", w / t - 1, w / t + 1, {8'h0, cap_result_byte});
    $display("test capture pin %0d polarity %0d ended", p, pol);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    #1 nrst = 1;
    @(posedge clk);
    #1 rc_read(3'h7, 255, 10 * T);
    rc_read(3'h0, 0, 10 * T);
    rc_read(3'h3, 128, 10 * T);
    rc_read(3'h5, 255, 0);
    for (int u = 0; u < 4; u++)
      cap_read(4'hf, 1'b1, u[1:0], 3 * (u == 1 ? 500 : u == 2 ? T : 2500)
               + T / 2);
    cap_read(4'h0, 1'b0, 2'h2, 7 * T);
    summarize();
  end
  initial
  begin
    #200000;
    error_cnt++;
    summarize();
  end
endmodule // testbench
